/* asq_seq_a_ctrl.sv */
`timescale 1ns/1ps
module asq_seq_a_ctrl
    import asq_pkg::*;
#(
    parameter int NUM_CH = ASQ_NUM_CH,
    parameter int NUM_TRIG = ASQ_NUM_TRIG
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Hardware trigger sources
    input wire logic [NUM_TRIG-1:0] hw_trig,
    // Converter handshake
    input wire logic conv_done,
    output logic conv_start,
    output logic [ASQ_CH_W-1:0] conv_channel,
    output logic seq_busy,
    output logic seq_done
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_hold;
        logic [31:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NUM_CH-1:0] chan_mask;
        logic [ASQ_TRIG_W-1:0] trig_sel;
        logic edge_pol;
        logic sync_skip;
        logic enable;
        logic sw_start;
    } asq_top_state_t;

    asq_top_state_t st_r;
    asq_top_state_t st_nxt;

    logic trig_pulse;
    logic launch;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] new_word;

    // ------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------
    // Start bit is a one-cycle event and always reads as zero
    always_comb begin
        ctrl_word = '0;
        ctrl_word[ASQ_MASK_LSB +: NUM_CH] = st_r.chan_mask;
        ctrl_word[ASQ_TRIG_LSB +: ASQ_TRIG_W] = st_r.trig_sel;
        ctrl_word[ASQ_POL_BIT] = st_r.edge_pol;
        ctrl_word[ASQ_SKIP_BIT] = st_r.sync_skip;
        ctrl_word[ASQ_ENA_BIT] = st_r.enable;
        stat_word = '0;
        stat_word[ASQ_STAT_BUSY_BIT] = seq_busy;
        stat_word[ASQ_STAT_CH_LSB +: ASQ_CH_W] = conv_channel;
    end

    // ------------------------------------------------------------
    // Bus slave and register file
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.sw_start = 1'b0;
        new_word = ctrl_word;

        // Address and data are captured independently
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_hold = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Commit once both halves are in and no answer is pending
        if (st_r.aw_hold && st_r.w_hold && !st_r.bvalid) begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = ASQ_RESP_OKAY;
            if (st_r.aw_addr == ASQ_CTRL_ADDR) begin
                for (int b = 0; b < 4; b++) begin
                    if (st_r.w_strb[b]) begin
                        new_word[8*b +: 8] = st_r.w_data[8*b +: 8];
                    end
                end
                // Mask and trigger settings take effect with the same
                // write that sets enable; no guard against changes made
                // while enabled, software owns that hazard
                st_nxt.chan_mask = new_word[ASQ_MASK_LSB +: NUM_CH];
                st_nxt.trig_sel = new_word[ASQ_TRIG_LSB +: ASQ_TRIG_W];
                st_nxt.edge_pol = new_word[ASQ_POL_BIT];
                st_nxt.sync_skip = new_word[ASQ_SKIP_BIT];
                st_nxt.enable = new_word[ASQ_ENA_BIT];
                st_nxt.sw_start = st_r.w_strb[ASQ_START_BIT / 8]
                    && st_r.w_data[ASQ_START_BIT]
                    && new_word[ASQ_ENA_BIT];
            end else if (st_r.aw_addr == ASQ_STAT_ADDR) begin
                st_nxt.bresp = ASQ_RESP_OKAY;
            end else begin
                st_nxt.bresp = ASQ_RESP_SLVERR;
            end
        end

        st_nxt.awready = !st_nxt.aw_hold;
        st_nxt.wready = !st_nxt.w_hold;

        // Read channel: one outstanding read
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            if (s_axi_araddr == ASQ_CTRL_ADDR) begin
                st_nxt.rdata = ctrl_word;
                st_nxt.rresp = ASQ_RESP_OKAY;
            end else if (s_axi_araddr == ASQ_STAT_ADDR) begin
                st_nxt.rdata = stat_word;
                st_nxt.rresp = ASQ_RESP_OKAY;
            end else begin
                st_nxt.rdata = '0;
                st_nxt.rresp = ASQ_RESP_SLVERR;
            end
        end
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.chan_mask <= ASQ_MASK_RST;
            st_r.trig_sel <= ASQ_TRIG_RST;
            st_r.edge_pol <= ASQ_POL_RST;
            st_r.sync_skip <= ASQ_SKIP_RST;
            st_r.enable <= ASQ_ENA_RST;
            st_r.bresp <= ASQ_RESP_OKAY;
            st_r.rresp <= ASQ_RESP_OKAY;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Trigger qualification and launch
    // ------------------------------------------------------------
    asq_trigger_qual #(
        .NUM_TRIG(NUM_TRIG),
        .TRIG_W(ASQ_TRIG_W)
    ) u_trig (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .hw_trig(hw_trig),
        .trig_sel(st_r.trig_sel),
        .trigger_edge_polarity(st_r.edge_pol),
        .sync_stage_skip(st_r.sync_skip),
        .sequence_a_enable(st_r.enable),
        .trig_pulse(trig_pulse)
    );

    // Either source launches the same pass
    assign launch = trig_pulse | st_r.sw_start;

    asq_channel_seq #(
        .NUM_CH(NUM_CH),
        .CH_W(ASQ_CH_W)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .launch(launch),
        .chan_mask(st_r.chan_mask),
        .conv_done(conv_done),
        .conv_start(conv_start),
        .conv_channel(conv_channel),
        .seq_busy(seq_busy),
        .seq_done(seq_done)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

endmodule

/* asq_pkg.sv */
package asq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] ASQ_CTRL_ADDR = 32'h4001c008;
    localparam logic [31:0] ASQ_STAT_ADDR = 32'h4001c0fc;

    // ------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------
    localparam int ASQ_NUM_CH = 12;
    localparam int ASQ_CH_W = 4;
    localparam int ASQ_NUM_TRIG = 8;
    localparam int ASQ_TRIG_W = 3;
    localparam int ASQ_MASK_LSB = 0;
    localparam int ASQ_TRIG_LSB = 12;
    localparam int ASQ_POL_BIT = 18;
    localparam int ASQ_SKIP_BIT = 19;
    localparam int ASQ_START_BIT = 26;
    localparam int ASQ_ENA_BIT = 31;

    localparam logic [11:0] ASQ_MASK_RST = 12'h000;
    localparam logic [2:0] ASQ_TRIG_RST = 3'h0;
    localparam logic ASQ_POL_RST = 1'b0;
    localparam logic ASQ_SKIP_RST = 1'b0;
    localparam logic ASQ_ENA_RST = 1'b0;

    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int ASQ_STAT_BUSY_BIT = 0;
    localparam int ASQ_STAT_CH_LSB = 4;

    // ------------------------------------------------------------
    // Bus answers and timing
    // ------------------------------------------------------------
    localparam logic [1:0] ASQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASQ_RESP_SLVERR = 2'h2;
    localparam int ASQ_SKIP_LATENCY = 2;

endpackage

/* asq_trigger_qual.sv */
`timescale 1ns/1ps
module asq_trigger_qual
    import asq_pkg::*;
#(
    parameter int NUM_TRIG = ASQ_NUM_TRIG,
    parameter int TRIG_W = ASQ_TRIG_W
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Trigger sources
    input wire logic [NUM_TRIG-1:0] hw_trig,
    // Configuration
    input wire logic [TRIG_W-1:0] trig_sel,
    input wire logic trigger_edge_polarity,
    input wire logic sync_stage_skip,
    input wire logic sequence_a_enable,
    // Qualified launch
    output logic trig_pulse
);

    typedef struct packed {
        logic [NUM_TRIG-1:0] sync1;
        logic [NUM_TRIG-1:0] sync2;
        logic prev;
        logic pulse;
    } asq_tq_state_t;

    asq_tq_state_t st_r;
    asq_tq_state_t st_nxt;
    logic level;

    always_comb begin
        st_nxt = st_r;
        // Two-stage synchroniser on every source
        st_nxt.sync1 = hw_trig;
        st_nxt.sync2 = st_r.sync1;
        // Bypass taps the raw pin, trading metastability margin for delay
        if (sync_stage_skip) begin
            level = hw_trig[trig_sel];
        end else begin
            level = st_r.sync2[trig_sel];
        end
        st_nxt.prev = level;
        st_nxt.pulse = 1'b0;
        if (sequence_a_enable) begin
            if (trigger_edge_polarity) begin
                st_nxt.pulse = level & ~st_r.prev;
            end else begin
                st_nxt.pulse = ~level & st_r.prev;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign trig_pulse = st_r.pulse;

endmodule

/* asq_channel_seq.sv */
`timescale 1ns/1ps
module asq_channel_seq
    import asq_pkg::*;
#(
    parameter int NUM_CH = ASQ_NUM_CH,
    parameter int CH_W = ASQ_CH_W
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Launch request and channel set
    input wire logic launch,
    input wire logic [NUM_CH-1:0] chan_mask,
    // Converter handshake
    input wire logic conv_done,
    output logic conv_start,
    output logic [CH_W-1:0] conv_channel,
    output logic seq_busy,
    output logic seq_done
);

    typedef enum logic [0:0] {
        SQ_IDLE,
        SQ_WAIT
    } asq_sq_mode_t;

    typedef struct packed {
        asq_sq_mode_t mode;
        logic [NUM_CH-1:0] pend;
        logic [CH_W-1:0] chan;
        logic start;
        logic busy;
        logic done;
    } asq_sq_state_t;

    asq_sq_state_t st_r;
    asq_sq_state_t st_nxt;

    function automatic logic [CH_W-1:0] lowest(input logic [NUM_CH-1:0] m);
        logic [CH_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = CH_W'(i);
            end
        end
        return idx;
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.start = 1'b0;
        st_nxt.done = 1'b0;
        case (st_r.mode)
            SQ_IDLE: begin
                // Launch with an empty set is dropped silently
                if (launch && (|chan_mask)) begin
                    st_nxt.chan = lowest(chan_mask);
                    st_nxt.pend = chan_mask;
                    st_nxt.pend[lowest(chan_mask)] = 1'b0;
                    st_nxt.start = 1'b1;
                    st_nxt.busy = 1'b1;
                    st_nxt.mode = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                // Launches during a pass are ignored
                if (conv_done) begin
                    if (|st_r.pend) begin
                        st_nxt.chan = lowest(st_r.pend);
                        st_nxt.pend[lowest(st_r.pend)] = 1'b0;
                        st_nxt.start = 1'b1;
                    end else begin
                        st_nxt.busy = 1'b0;
                        st_nxt.done = 1'b1;
                        st_nxt.mode = SQ_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.mode = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign conv_start = st_r.start;
    assign conv_channel = st_r.chan;
    assign seq_busy = st_r.busy;
    assign seq_done = st_r.done;

endmodule

/* asq_trig_src.sv */
`timescale 1ns/1ps
module asq_trig_src
    import asq_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Converter handshake
    input wire logic conv_start,
    output logic conv_done,
    // Trigger lines
    output logic [ASQ_NUM_TRIG-1:0] hw_trig
);
    logic [2:0] wait_r;
    logic [1:0] pace_r;
    initial begin
        hw_trig = '0;
        conv_done = 1'b0;
        wait_r = 3'h0;
        pace_r = 2'h0;
    end
    // Answer time steps 2..5 clocks after conv_start, then wraps, so fast and slow paths both run
    always @(posedge aclk) begin
        conv_done <= 1'b0;
        if (!aresetn) begin
            wait_r <= 3'h0;
        end else if (conv_start) begin
            wait_r <= {1'b0, pace_r} + 3'h1;
            pace_r <= pace_r + 2'h1;
        end else if (wait_r != 3'h0) begin
            wait_r <= wait_r - 3'h1;
            conv_done <= (wait_r == 3'h1);
        end
    end
    // Lines change only on aclk, held at least one clock
    task automatic set_idle(input logic [ASQ_NUM_TRIG-1:0] v);
        @(posedge aclk);
        hw_trig <= v;
    endtask
    task automatic pulse(input int idx, input int w);
        @(posedge aclk);
        hw_trig[idx] <= ~hw_trig[idx];
        repeat (w) @(posedge aclk);
        hw_trig[idx] <= ~hw_trig[idx];
    endtask
endmodule

/* asq_seq_a_ctrl_assertions.sv */
`timescale 1ns/1ps
module asq_seq_a_ctrl_assertions
    import asq_pkg::*;
#(
    parameter int NUM_CH = ASQ_NUM_CH
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answers
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_arready,
    // Converter side
    input wire logic conv_done,
    input wire logic conv_start,
    input wire logic [ASQ_CH_W-1:0] conv_channel,
    input wire logic seq_busy,
    input wire logic seq_done
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_start_busy: assert property (conv_start |-> seq_busy)
        else $error("start outside a pass");
    a_chan_range: assert property (conv_start |-> conv_channel < NUM_CH)
        else $error("channel out of range");
    a_chan_ascend: assert property (conv_start && $past(seq_busy) |->
        conv_channel > $past(conv_channel)) else $error("channel not rising");
    a_done_next: assert property (conv_done && seq_busy |=>
        conv_start ^ seq_done) else $error("no next step");
    a_done_ends: assert property (seq_done |->
        !seq_busy && $past(seq_busy)) else $error("done without pass");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start not a pulse");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_start_reads0: assert property (s_axi_rvalid |->
        s_axi_rdata[ASQ_START_BIT] == 1'b0) else $error("start bit read 1");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
endmodule
bind asq_seq_a_ctrl asq_seq_a_ctrl_assertions #(.NUM_CH(NUM_CH))
    asq_seq_a_ctrl_assertions_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_arready(s_axi_arready), .conv_done(conv_done),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .seq_busy(seq_busy), .seq_done(seq_done)
);

/* tb_asq_seq_a_ctrl.sv */
`timescale 1ns/1ps
module tb_asq_seq_a_ctrl;
    import asq_pkg::*;
    logic aclk, aresetn, ce, awv, wv, bry, arv, rry;
    logic awr, wr, bv, arr, rv, cs, cd, busy, done;
    logic [31:0] awa, wd, ara, rd, cw;
    logic [3:0] ws, ch;
    logic [1:0] br, rr, resp;
    logic [7:0] trg;
    logic [11:0] m;
    logic [2:0] sel;
    int bad_count, cmp_count, seed, cyc, w;
    asq_seq_a_ctrl asq_seq_a_ctrl_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .hw_trig(trg), .conv_done(cd),
        .conv_start(cs), .conv_channel(ch), .seq_busy(busy),
        .seq_done(done)
    );
    asq_trig_src asq_trig_src_inst (
        .aclk(aclk), .aresetn(aresetn), .conv_start(cs),
        .conv_done(cd), .hw_trig(trg)
    );
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Both channels offered together, bready held until answer
    task automatic wrc(input logic [31:0] a, d, input logic [3:0] s,
                       input logic [1:0] er);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) break;
        end
        resp = br;
        bry <= 1'b0;
        check({30'h0, resp}, {30'h0, er});
    endtask
    task automatic rdc(input logic [31:0] a, exp, input logic [1:0] er);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        rry <= 1'b0;
        check(rd, exp);
        check({30'h0, rr}, {30'h0, er});
    endtask
    // Latency to first start, then each enabled channel in turn
    task automatic run_pass(input logic [11:0] pm, input int lat);
        int n;
        n = 0;
        while (!cs && n < 40) begin
            @(posedge aclk);
            n++;
        end
        check(32'(n), 32'(lat));
        for (int i = 0; i < ASQ_NUM_CH; i++) begin
            if (pm[i]) begin
                while (!cs && n < 400) begin
                    @(posedge aclk);
                    n++;
                end
                check({28'h0, ch}, 32'(i));
                @(posedge aclk);
            end
        end
        while (!done && n < 400) begin
            @(posedge aclk);
            n++;
        end
        check({31'h0, done}, 32'h1);
    endtask
    task automatic quiet();
        repeat (10) @(posedge aclk);
        check({31'h0, busy}, 32'h0);
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        seed = 587;
        {aresetn, awv, wv, bry, arv, rry} = '0;
        {awa, wd, ara, ws} = '0;
        ce = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(ASQ_CTRL_ADDR, 32'h0, ASQ_RESP_OKAY);
        rdc(ASQ_CTRL_ADDR + 32'h4, 32'h0, ASQ_RESP_SLVERR);
        wrc(ASQ_CTRL_ADDR + 32'h4, 32'hffff_ffff, 4'hf, ASQ_RESP_SLVERR);
        for (int k = 0; k < 4; k++) begin
            sel = 3'($random(seed));
            m = 12'($random(seed));
            if (k == 0) m = 12'h800;
            if (k == 3 || m == 12'h0) m = 12'hfff;
            w = 1 + int'($unsigned($random(seed)) % 3);
            // Config changed only while disabled
            wrc(ASQ_CTRL_ADDR, 32'h0, 4'hf, ASQ_RESP_OKAY);
            asq_trig_src_inst.set_idle(k[0] ? 8'h00 : 8'hff);
            cw = {1'b1, 11'h0, k[1], k[0], 3'h0, sel, m};
            wrc(ASQ_CTRL_ADDR, cw, 4'hf, ASQ_RESP_OKAY);
            rdc(ASQ_CTRL_ADDR, cw, ASQ_RESP_OKAY);
            asq_trig_src_inst.pulse(int'(sel ^ 3'h1), w);
            quiet();
            fork
                asq_trig_src_inst.pulse(int'(sel), w);
                begin
                    @(posedge aclk);
                    run_pass(m, k[1] ? 3 : 5);
                end
            join
            quiet();
        end
        wrc(ASQ_CTRL_ADDR, 32'h0000_000f, 4'hf, ASQ_RESP_OKAY);
        asq_trig_src_inst.pulse(0, 1);
        quiet();
        wrc(ASQ_CTRL_ADDR, 32'h0400_000f, 4'hf, ASQ_RESP_OKAY);
        quiet();
        wrc(ASQ_CTRL_ADDR, 32'h8400_0005, 4'hf, ASQ_RESP_OKAY);
        run_pass(12'h005, 1);
        rdc(ASQ_CTRL_ADDR, 32'h8000_0005, ASQ_RESP_OKAY);
        wrc(ASQ_CTRL_ADDR, 32'h8400_0003, 4'h7, ASQ_RESP_OKAY);
        quiet();
        rdc(ASQ_CTRL_ADDR, 32'h8000_0003, ASQ_RESP_OKAY);
        test_done();
    end
endmodule
